// ===== dv/snvm_assertions.sv
// Purpose: Link checks between the host end and the memory end.
// Assumes: The link clock is made from I_MCLK, so no resync is needed.
// Notes: Bits are counted on rising link clock edges within a frame.
`default_nettype none
module snvm_chk (
    input wire logic I_MCLK,
    input wire logic I_NRST,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic guard_n
);
    import snvm_pkg::*;
    logic sck_q;
    logic [15:0] bits;
    logic [7:0] sh;
    logic [7:0] op;
    logic rise;
    logic is_rd;
    assign rise = sck && !sck_q && !cs_n;
    assign is_rd = (op & SNVM_OP_RD_MASK) == SNVM_OP_RD;
    // ====================
    // Frame tracking
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sck_q <= 1'b0;
            bits <= 16'h0;
            sh <= 8'h0;
            op <= 8'h0;
        end else begin
            sck_q <= sck;
            if (cs_n) begin
                bits <= 16'h0;
                op <= 8'h0;
            end else if (rise) begin
                bits <= bits + 16'h1;
                sh <= {sh[6:0], si};
                if (bits == 16'h7) begin
                    op <= {sh[6:0], si};
                end
            end
        end
    end
    // ====================
    // Properties
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    rst_idle_a: assert property ($rose(I_NRST) |-> cs_n && !so_oe)
        else $error("link not idle after reset");
    out_release_a: assert property (cs_n [*4] |-> !so_oe)
        else $error("data out driven while deselected");
    early_drive_a: assert property (!cs_n && bits != 16'h0 &&
        bits < 16'h8 |-> !so_oe)
        else $error("data out driven during the command byte");
    bad_op_a: assert property (!cs_n && bits >= 16'h8 &&
        op != SNVM_OP_STRD && !is_rd |-> !so_oe)
        else $error("data out driven for a non-read command");
    drive_start_a: assert property ($rose(so_oe) |->
        bits == (is_rd ? 16'h10 : 16'h8))
        else $error("data out enabled at the wrong bit");
    out_edge_a: assert property (so_oe && $past(so_oe) &&
        $changed(so) |-> !sck)
        else $error("data out changed while link clock high");
    in_hold_a: assert property (!cs_n && bits[2:0] != 3'h0 &&
        sck && $past(sck) |-> $stable(si))
        else $error("data in changed while link clock high");
    whole_byte_a: assert property ($rose(cs_n) |-> bits[2:0] == 3'h0)
        else $error("frame ended inside a byte");
    mode_hold_a: assert property ($fell(cs_n) |-> $stable(sck))
        else $error("link clock moved at selection");
    read_hold_a: assert property (so_oe && !cs_n && is_rd |=>
        so_oe || cs_n)
        else $error("read burst output dropped");
    guard_low_c: cover property (!cs_n && !guard_n);
endmodule
`default_nettype wire

// ===== dv/spi_nv_memory_command_protect_tb_top.sv
// Purpose: Drives the host register port against the memory end.
// Assumes: Host control bits: 0 send, 1 end frame, 2 guard, 3 mode3.
// Notes: A shadow of array and status predicts every array and status read back.
`default_nettype none
module spi_nv_memory_command_protect_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import snvm_pkg::*;
    logic clk;
    logic rst_n;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic busy;
    logic [7:0] status;
    int fails;
    int check_count;
    logic [7:0] ctl;
    logic [1:0] bg_m;
    logic wef_m;
    logic [7:0] mem_m [SNVM_DEPTH];
    snvm_if snvm_if_i ();
    snvm_host snvm_host_i (.I_MCLK(clk), .I_NRST(rst_n), .LINK(snvm_if_i),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .O_BUSY(busy));
    snvm_dev snvm_dev_i (.I_MCLK(clk), .I_NRST(rst_n), .LINK(snvm_if_i),
        .O_STATUS(status));
    snvm_chk snvm_chk_i (.I_MCLK(clk), .I_NRST(rst_n),
        .cs_n(snvm_if_i.cs_n), .sck(snvm_if_i.sck), .si(snvm_if_i.si),
        .so(snvm_if_i.so), .so_oe(snvm_if_i.so_oe),
        .guard_n(snvm_if_i.guard_n));
    // ====================
    // Bus and frame tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        // Busy rises two edges after the start strobe; let one edge pass.
        @(posedge clk);
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            fails++;
            $display("Error at %0t: host stuck busy", $time);
            stop_test();
        end
    endtask
    task automatic xfer(input logic [7:0] b, output logic [7:0] rx);
        reg_wr(2'h0, b);
        reg_wr(2'h1, ctl | 8'h01);
        wait_idle();
        reg_rd(2'h0, rx);
    endtask
    task automatic endf;
        reg_wr(2'h1, ctl | 8'h02);
        wait_idle();
    endtask
    task automatic set_ctl(input logic [7:0] c);
        ctl = c;
        reg_wr(2'h1, ctl);
    endtask
    task automatic cmd1(input logic [7:0] op);
        logic [7:0] rx;
        xfer(op, rx);
        endf();
        if (op == SNVM_OP_WLSET) begin
            wef_m = 1'b1;
        end
    endtask
    task automatic stwr(input logic [7:0] d);
        logic [7:0] rx;
        xfer(SNVM_OP_STWR, rx);
        xfer(d, rx);
        endf();
        if (wef_m && ctl[2]) begin
            bg_m = d[3:2];
        end
        wef_m = 1'b0;
    endtask
    task automatic chk_st;
        logic [7:0] s;
        xfer(SNVM_OP_STRD, s);
        xfer(8'h00, s);
        endf();
        chk(s, {4'h0, bg_m, wef_m, 1'b0});
        chk(status, {4'h0, bg_m, wef_m, 1'b0});
    endtask
    function automatic logic prot(input logic [8:0] a);
        case (bg_m)
            2'h1: return a >= SNVM_QUARTER_BASE;
            2'h2: return a >= SNVM_HALF_BASE;
            2'h3: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic mem_wr(input logic [8:0] a, input logic [15:0] d);
        logic [7:0] rx;
        logic stop;
        stop = !(wef_m && ctl[2]);
        xfer(SNVM_OP_WR | {4'h0, a[8], 3'h0}, rx);
        xfer(a[7:0], rx);
        for (int i = 0; i < 2; i++) begin
            xfer(d[15-8*i -: 8], rx);
            stop = stop || prot(a);
            if (!stop) begin
                mem_m[a] = d[15-8*i -: 8];
                a++;
            end
        end
        endf();
        wef_m = 1'b0;
    endtask
    // The read sends set-latch bytes, which must be ignored as input.
    task automatic mem_rd(input logic [8:0] a);
        logic [7:0] r;
        xfer(SNVM_OP_RD | {4'h0, a[8], 3'h0}, r);
        xfer(a[7:0], r);
        for (int i = 0; i < 2; i++) begin
            xfer(SNVM_OP_WLSET, r);
            chk(r, mem_m[a]);
            a++;
        end
        endf();
    endtask
    task automatic wr_rd(input logic [8:0] a, input logic [15:0] d,
                         input logic en);
        if (en) begin
            cmd1(SNVM_OP_WLSET);
        end
        mem_wr(a, d);
        mem_rd(a);
    endtask
    // ====================
    // Scenarios
    task automatic t_latch;
        logic [7:0] rx;
        xfer(8'hFF, rx);
        xfer(SNVM_OP_WLSET, rx);
        endf();
        chk_st();
        xfer(SNVM_OP_WLSET, rx);
        xfer(SNVM_OP_WLCLR, rx);
        endf();
        wef_m = 1'b1;
        chk_st();
        cmd1(SNVM_OP_WLCLR);
        wef_m = 1'b0;
        chk_st();
    endtask
    task automatic t_stwr;
        stwr(8'hFF);
        chk_st();
        cmd1(SNVM_OP_WLSET);
        set_ctl(8'h00);
        stwr(8'hFF);
        chk_st();
        set_ctl(8'h04);
        cmd1(SNVM_OP_WLSET);
        chk_st();
        stwr(8'hF6);
        chk_st();
    endtask
    task automatic t_guard;
        for (int g = 0; g < 4; g++) begin
            cmd1(SNVM_OP_WLSET);
            stwr({4'h0, g[1:0], 2'h0});
            chk_st();
            wr_rd(9'h0FF, {8'h10 + 8'(g), 8'h90 + 8'(g)}, 1'b1);
            wr_rd(9'h17F, {8'h50 + 8'(g), 8'hD0 + 8'(g)}, 1'b1);
        end
        cmd1(SNVM_OP_WLSET);
        stwr(8'h00);
        wr_rd(9'h17F, 16'hC33C, 1'b0);
        set_ctl(8'h00);
        wr_rd(9'h17F, 16'h3CC3, 1'b1);
        set_ctl(8'h04);
    endtask
    task automatic t_wrap;
        logic [7:0] r;
        cmd1(SNVM_OP_WLSET);
        mem_wr(9'h1FF, 16'hA55A);
        set_ctl(8'h0C);
        reg_rd(2'h1, r);
        chk(r, 8'h0C);
        mem_rd(9'h1FF);
        chk_st();
        set_ctl(8'h04);
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ====================
    // Clock, reset, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        ctl = 8'h04;
        bg_m = 2'h0;
        wef_m = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_st();
        t_latch();
        t_stwr();
        t_guard();
        t_wrap();
        stop_test();
    end
    // Far above the roughly 12000 cycles the sequence needs.
    initial begin
        #3200000;
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
`default_nettype wire

// ===== hw/snvm_dev.sv
// Purpose: Serial memory slave: commands, protection and burst access.
// Assumes: Link pins are asynchronous and oversampled by I_MCLK.
// Notes: Guard bits sit in flops that reset clears and an enabled status write loads.
//
// Implementation choices: the plain strobed port and the register addresses.
`default_nettype none
module snvm_dev (
    input wire logic I_MCLK,
    input wire logic I_NRST,
    snvm_if.dev LINK,
    output logic [7:0] O_STATUS
);
    import snvm_pkg::*;
    logic [7:0] mem_r [SNVM_DEPTH];
    snvm_dst_t st_r;
    logic [2:0] cs_sy_r, sck_sy_r;
    logic [1:0] si_sy_r, g_sy_r;
    logic cs_n, si_s, guard_ok;
    logic sck_rise, sck_fall, cs_fall, cs_rise;
    logic [7:0] sh_r, out_r;
    logic [2:0] cnt_r;
    logic [8:0] addr_r;
    logic wef_r, halt_r, clr_pend_r, so_oe_r, so_r;
    logic [1:0] bg_r;
    logic [7:0] byte_in;
    logic byte_done;
    logic rd_cmd_r;
    logic wr_ok;

    function automatic logic is_prot(input logic [1:0] bg,
                                     input logic [8:0] a);
        unique case (bg)
            2'h0: is_prot = 1'b0;
            2'h1: is_prot = (a >= SNVM_QUARTER_BASE);
            2'h2: is_prot = (a >= SNVM_HALF_BASE);
            2'h3: is_prot = 1'b1;
        endcase
    endfunction

    // ===========================================================
    // Pin synchronisers
    // ===========================================================
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cs_sy_r <= 3'h7;
            sck_sy_r <= 3'h0;
            si_sy_r <= 2'h0;
            g_sy_r <= 2'h0;
        end else begin
            cs_sy_r <= {cs_sy_r[1:0], LINK.cs_n};
            sck_sy_r <= {sck_sy_r[1:0], LINK.sck};
            si_sy_r <= {si_sy_r[0], LINK.si};
            g_sy_r <= {g_sy_r[0], LINK.guard_n};
        end
    end
    assign cs_n = cs_sy_r[1];
    assign si_s = si_sy_r[1];
    assign guard_ok = g_sy_r[1];
    assign cs_fall = cs_sy_r[2] & ~cs_sy_r[1];
    assign cs_rise = ~cs_sy_r[2] & cs_sy_r[1];
    // edges only while selected
    // A mode 3 clock idles high, so selection alone never makes a rise.
    assign sck_rise = ~cs_n & ~sck_sy_r[2] & sck_sy_r[1];
    assign sck_fall = ~cs_n & sck_sy_r[2] & ~sck_sy_r[1];
    assign byte_in = {sh_r[6:0], si_s};
    assign byte_done = sck_rise && cnt_r == 3'h7;

    // ===========================================================
    // Receive shifter
    // ===========================================================
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sh_r <= 8'h00;
            cnt_r <= 3'h0;
        end else if (cs_fall || cs_n) begin
            cnt_r <= 3'h0;
        end else if (sck_rise) begin
            sh_r <= byte_in;
            cnt_r <= cnt_r + 3'h1;
        end
    end

    // ===========================================================
    // Command engine
    // ===========================================================
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_r <= SNVM_D_IGN;
            addr_r <= 9'h000;
            halt_r <= 1'b0;
            clr_pend_r <= 1'b0;
        end else if (cs_fall) begin
            st_r <= SNVM_D_CMD;
            halt_r <= 1'b0;
            clr_pend_r <= 1'b0;
        end else if (cs_n) begin
            st_r <= SNVM_D_IGN;
        end else if (byte_done) begin
            unique case (st_r)
                SNVM_D_CMD: begin
                    addr_r <= {byte_in[SNVM_OP_A8_BIT], 8'h00};
                    if (byte_in == SNVM_OP_WLCLR) begin
                        clr_pend_r <= 1'b1;
                        st_r <= SNVM_D_IGN;
                    end else if (byte_in == SNVM_OP_STRD) begin
                        st_r <= SNVM_D_STAT;
                    end else if (byte_in == SNVM_OP_STWR) begin
                        clr_pend_r <= 1'b1;
                        st_r <= SNVM_D_STWR;
                    end else if ((byte_in & SNVM_OP_RD_MASK) == SNVM_OP_RD
                                 || (byte_in & SNVM_OP_RD_MASK)
                                 == SNVM_OP_WR) begin
                        clr_pend_r <= ~byte_in[0];
                        st_r <= SNVM_D_ADDR;
                    end else begin
                        st_r <= SNVM_D_IGN;
                    end
                end
                SNVM_D_ADDR: begin
                    addr_r <= {addr_r[8], byte_in};
                    st_r <= rd_cmd_r ? SNVM_D_RDATA : SNVM_D_WDATA;
                end
                SNVM_D_WDATA: begin
                    if (!halt_r) begin
                        if (!wr_ok) begin
                            halt_r <= 1'b1;
                        end else begin
                            addr_r <= addr_r + 9'h001;
                        end
                    end
                end
                SNVM_D_RDATA: begin
                    addr_r <= addr_r + 9'h001;
                end
                SNVM_D_STWR: st_r <= SNVM_D_IGN;
                SNVM_D_STAT: st_r <= SNVM_D_IGN;
                SNVM_D_IGN: st_r <= SNVM_D_IGN;
            endcase
        end
    end

    // flag and guard pin gate writes
    assign wr_ok = wef_r & guard_ok & ~is_prot(bg_r, addr_r);
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rd_cmd_r <= 1'b0;
        end else if (byte_done && st_r == SNVM_D_CMD) begin
            rd_cmd_r <= byte_in[0];
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!cs_n && byte_done && st_r == SNVM_D_WDATA
            && !halt_r && wr_ok) begin
            mem_r[addr_r] <= byte_in;
        end
    end

    // ===========================================================
    // Protection status
    // ===========================================================
    // flag cleared at reset
    // defect not modelled: flag always clears after write
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            wef_r <= 1'b0;
        end else if (!cs_n && byte_done && st_r == SNVM_D_CMD
                     && byte_in == SNVM_OP_WLSET) begin
            wef_r <= 1'b1;
        end else if (cs_rise && clr_pend_r) begin
            wef_r <= 1'b0;
        end
    end
    // guard bits cleared by reset, loaded from a status write with flag set and guard pin high
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            bg_r <= SNVM_BG_RESET;
        end else if (!cs_n && byte_done && st_r == SNVM_D_STWR
                     && wef_r && guard_ok) begin
            bg_r <= {byte_in[SNVM_ST_BGH_BIT], byte_in[SNVM_ST_BGL_BIT]};
        end
    end

    // ===========================================================
    // Transmit path
    // ===========================================================
    // fixed zero status bits
    logic [7:0] status;
    always_comb begin
        status = 8'h00;
        status[SNVM_ST_WEF_BIT] = wef_r;
        status[SNVM_ST_BGL_BIT] = bg_r[0];
        status[SNVM_ST_BGH_BIT] = bg_r[1];
    end
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            out_r <= 8'h00;
            so_r <= 1'b0;
            so_oe_r <= 1'b0;
            O_STATUS <= 8'h00;
        end else begin
            O_STATUS <= status;
            if (cs_n || cs_fall) begin
                so_oe_r <= 1'b0;
                so_r <= 1'b0;
            end else if (byte_done && st_r == SNVM_D_CMD
                         && byte_in == SNVM_OP_STRD) begin
                out_r <= status;
            end else if (byte_done && (st_r == SNVM_D_ADDR && rd_cmd_r)) begin
                out_r <= mem_r[{addr_r[8], byte_in}];
            end else if (byte_done && st_r == SNVM_D_RDATA) begin
                out_r <= mem_r[addr_r + 9'h001];
            end else if (sck_fall && (st_r == SNVM_D_STAT
                         || st_r == SNVM_D_RDATA)) begin
                so_oe_r <= 1'b1;
                so_r <= out_r[7];
                out_r <= {out_r[6:0], 1'b0};
            end else if (sck_fall && st_r != SNVM_D_IGN) begin
                so_oe_r <= 1'b0;
            end else if (st_r == SNVM_D_IGN && cnt_r == 3'h0 && sck_fall) begin
                so_oe_r <= 1'b0;
            end
        end
    end
    assign LINK.so = so_r;
    assign LINK.so_oe = so_oe_r;
endmodule
`default_nettype wire

// ===== hw/snvm_host.sv
// Purpose: Serial link master driven by a simple register port.
// Assumes: Software sequences frames byte by byte.
// Notes: 0x0 data, 0x1 control/status; read data one cycle later.
`default_nettype none
module snvm_host (
    input wire logic I_MCLK,
    input wire logic I_NRST,
    snvm_if.hst LINK,
    input wire logic [1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    output logic O_BUSY
);
    import snvm_pkg::*;
    snvm_hst_t st_r;
    logic [7:0] tx_r, rx_r;
    logic [2:0] bit_r;
    logic [7:0] cnt_r;
    logic cs_n_r, sck_r, si_r, guard_n_r, mode3_r;
    logic so_s1_r, so_s2_r;
    logic tick;
    assign tick = (cnt_r == 8'(SNVM_SCK_HALF_CYC - 1));
    assign LINK.cs_n = cs_n_r;
    assign LINK.sck = sck_r;
    assign LINK.si = si_r;
    assign LINK.guard_n = guard_n_r;
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            so_s1_r <= 1'b0;
            so_s2_r <= 1'b0;
        end else begin
            so_s1_r <= LINK.so & LINK.so_oe;
            so_s2_r <= so_s1_r;
        end
    end
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cnt_r <= 8'h00;
        end else if (tick || st_r == SNVM_H_IDLE) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    // Control write: bit0 start byte, bit1 end frame, bit2 guard, bit3 mode3.
    // one command per select
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_r <= SNVM_H_IDLE;
            cs_n_r <= 1'b1;
            sck_r <= 1'b0;
            si_r <= 1'b0;
            guard_n_r <= 1'b1;
            mode3_r <= 1'b0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            bit_r <= 3'h0;
        end else begin
            unique case (st_r)
                SNVM_H_IDLE: begin
                    if (I_WR && I_ADDR == 2'h0) begin
                        tx_r <= I_WDATA;
                    end
                    if (I_WR && I_ADDR == 2'h1) begin
                        guard_n_r <= I_WDATA[2];
                        mode3_r <= I_WDATA[3];
                        if (!cs_n_r) begin
                            sck_r <= mode3_r;
                        end else begin
                            sck_r <= I_WDATA[3];
                        end
                        if (I_WDATA[1]) begin
                            st_r <= SNVM_H_END;
                        end else if (I_WDATA[0]) begin
                            st_r <= SNVM_H_SEL;
                        end
                    end
                end
                SNVM_H_SEL: begin
                    cs_n_r <= 1'b0;
                    bit_r <= 3'h7;
                    if (tick) begin
                        si_r <= tx_r[7];
                        sck_r <= 1'b0;
                        st_r <= SNVM_H_LO;
                    end
                end
                SNVM_H_LO: begin
                    if (tick) begin
                        sck_r <= 1'b1;
                        st_r <= SNVM_H_HI;
                    end
                end
                SNVM_H_HI: begin
                    if (tick) begin
                        rx_r <= {rx_r[6:0], so_s2_r};
                        tx_r <= {tx_r[6:0], 1'b0};
                        if (bit_r == 3'h0) begin
                            sck_r <= mode3_r;
                            st_r <= SNVM_H_IDLE;
                        end else begin
                            bit_r <= bit_r - 3'h1;
                            sck_r <= 1'b0;
                            si_r <= tx_r[6];
                            st_r <= SNVM_H_LO;
                        end
                    end
                end
                SNVM_H_END: begin
                    if (tick) begin
                        cs_n_r <= 1'b1;
                        st_r <= SNVM_H_IDLE;
                    end
                end
                default: st_r <= SNVM_H_IDLE;
            endcase
        end
    end
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_RDATA <= 8'h00;
            O_BUSY <= 1'b0;
        end else begin
            O_BUSY <= (st_r != SNVM_H_IDLE);
            if (I_RD) begin
                O_RDATA <= (I_ADDR == 2'h0) ? rx_r :
                           {4'h0, mode3_r, guard_n_r, ~cs_n_r,
                            st_r != SNVM_H_IDLE};
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/snvm_if.sv
// Purpose: Five-wire serial link between host and memory.
// Assumes: Output enable of the data out pin is high while device drives.
// Notes: Host samples the data out wire as so gated by so_oe.
`default_nettype none
interface snvm_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic guard_n;
    modport dev (input cs_n, input sck, input si, input guard_n,
                 output so, output so_oe);
    modport hst (output cs_n, output sck, output si, output guard_n,
                 input so, input so_oe);
endinterface
`default_nettype wire

// ===== hw/snvm_pkg.sv
// Purpose: Shared constants and types for the serial nonvolatile memory link.
// Assumes: One system clock at 25 MHz samples all link pins.
`default_nettype none
package snvm_pkg;
    localparam int unsigned SNVM_ADDR_W = 9;
    localparam int unsigned SNVM_DEPTH = 512;
    localparam logic [7:0] SNVM_OP_WLSET = 8'h06;
    localparam logic [7:0] SNVM_OP_WLCLR = 8'h04;
    localparam logic [7:0] SNVM_OP_STRD = 8'h05;
    localparam logic [7:0] SNVM_OP_STWR = 8'h01;
    localparam logic [7:0] SNVM_OP_RD_MASK = 8'hF7;
    localparam logic [7:0] SNVM_OP_RD = 8'h03;
    localparam logic [7:0] SNVM_OP_WR = 8'h02;
    localparam int unsigned SNVM_OP_A8_BIT = 3;
    localparam int unsigned SNVM_ST_WEF_BIT = 1;
    localparam int unsigned SNVM_ST_BGL_BIT = 2;
    localparam int unsigned SNVM_ST_BGH_BIT = 3;
    localparam logic [1:0] SNVM_BG_RESET = 2'h0;
    localparam logic [8:0] SNVM_QUARTER_BASE = 9'h180;
    localparam logic [8:0] SNVM_HALF_BASE = 9'h100;
    // Host link clock divider: half period in system clocks (160 ns).
    localparam int unsigned SNVM_SCK_HALF_NS = 160;
    localparam int unsigned SNVM_CLK_NS = 40;
    localparam int unsigned SNVM_SCK_HALF_CYC = SNVM_SCK_HALF_NS / SNVM_CLK_NS;
    typedef enum logic [2:0] {
        SNVM_H_IDLE, SNVM_H_SEL, SNVM_H_LO, SNVM_H_HI, SNVM_H_END
    } snvm_hst_t;
    typedef enum logic [2:0] {
        SNVM_D_CMD, SNVM_D_ADDR, SNVM_D_WDATA, SNVM_D_RDATA,
        SNVM_D_STAT, SNVM_D_STWR, SNVM_D_IGN
    } snvm_dst_t;
endpackage
`default_nettype wire
